/* File: src/tpl_control.sv */
// Contract
// - Line generator sends the selected pattern while bit 13 is set.
// - Line checker compares received data against selected pattern while bit 12 set.
// - Line select decodes eight codes: freq, CRPAT, PRBS7/23/31; reset code 101.
// - Line freq/CRPAT only in 1G-KX and 10G; PRBS also in 10G-KR.
// - Lane select is bit 11 on top of bits 5:4.
// - Lane generator sends the selected lane pattern while bit 7 is set.
// - Lane checker verifies against selected lane pattern while bit 6 is set.
// - Lane select uses the same eight codes, reset code 101.
// - Lane CRPAT codes 011 and 100 only in 1G-KX mode.
// - Control register resets to 0x0d10, all enables cleared.
// - Bit 3 set enables deep remote loopback.
// - Bit 0 set enables shallow local loopback.
`timescale 1ns/100ps
`include "tpl_regs.svh"

module tpl_control
(
  // clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST,
  // management register port
  input  wire logic [`TPL_ADDR_W-1:0]    MGMT_ADDR,
  input  wire logic                      MGMT_WR,
  input  wire logic                      MGMT_RD,
  input  wire logic [15:0]               MGMT_WDATA,
  output logic      [15:0]               MGMT_RDATA,
  // core mode and checker result
  input  wire tpl_pkg::tpl_mode_e        DEV_MODE,
  input  wire logic                      LINE_MISMATCH,
  // controls to the datapath
  output tpl_pkg::tpl_side_s             LINE_CTRL,
  output tpl_pkg::tpl_side_s             LANE_CTRL,
  output logic                           FAR_DEEP_LOOPBACK,
  output logic                           NEAR_SHALLOW_LOOPBACK
);
  import tpl_pkg::*;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic [15:0] ctrl_r;
  logic [15:0] errcnt_r;
  logic [15:0] rdata_r;

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      ctrl_r <= `TPL_CTRL_RESET;
    else if (MGMT_WR && (MGMT_ADDR == `TPL_CTRL_ADDR))
      ctrl_r <= MGMT_WDATA;  // reserved bits stay writable and read back as written
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic     line_side_gen_enable;
  logic     line_side_check_enable;
  tpl_pat_e line_side_pattern_select;
  logic     lane_side_gen_enable;
  logic     lane_side_check_enable;
  tpl_pat_e lane_side_pattern_select;
  logic     line_ok;
  logic     lane_ok;

  assign line_side_pattern_select =
    tpl_pat_e'(ctrl_r[`TPL_LINE_SEL_MSB:`TPL_LINE_SEL_LSB]);
  // lane select assembled from split field
  assign lane_side_pattern_select =
    tpl_pat_e'({ctrl_r[`TPL_LANE_SEL_HI_BIT], ctrl_r[`TPL_LANE_SEL_MSB:`TPL_LANE_SEL_LSB]});
  assign line_side_gen_enable   = ctrl_r[`TPL_LINE_GEN_BIT];
  assign line_side_check_enable = ctrl_r[`TPL_LINE_CHK_BIT];
  assign lane_side_gen_enable   = ctrl_r[`TPL_LANE_GEN_BIT];
  assign lane_side_check_enable = ctrl_r[`TPL_LANE_CHK_BIT];

  // line pattern support by mode; prbs covers kr too
  always_comb
  begin
    line_ok = 1'b0;
    unique case (line_side_pattern_select)
      TPL_PAT_PRBS7, TPL_PAT_PRBS23, TPL_PAT_PRBS31:
        line_ok = (DEV_MODE == TPL_MODE_1G_KX) || (DEV_MODE == TPL_MODE_10G)
               || (DEV_MODE == TPL_MODE_10G_KR);
      TPL_PAT_HIGH_FREQ, TPL_PAT_LOW_FREQ, TPL_PAT_MIXED_FREQ,
      TPL_PAT_CRPAT_LONG, TPL_PAT_CRPAT_SHRT:
        line_ok = (DEV_MODE == TPL_MODE_1G_KX) || (DEV_MODE == TPL_MODE_10G);
    endcase
  end

  // lane crpat only in 1g-kx; other codes in any mode
  // same eight codes as the line side
  always_comb
  begin
    lane_ok = 1'b1;
    unique case (lane_side_pattern_select)
      TPL_PAT_CRPAT_LONG, TPL_PAT_CRPAT_SHRT:
        lane_ok = (DEV_MODE == TPL_MODE_1G_KX);
      TPL_PAT_HIGH_FREQ, TPL_PAT_LOW_FREQ, TPL_PAT_MIXED_FREQ,
      TPL_PAT_PRBS7, TPL_PAT_PRBS23, TPL_PAT_PRBS31:
        lane_ok = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // checker realignment
  // ---------------------------------------------------------------
  logic       line_chk_q_r;
  logic       lane_chk_q_r;
  tpl_pat_e   line_sel_q_r;
  tpl_pat_e   lane_sel_q_r;
  logic       line_restart_r;
  logic       lane_restart_r;

  // one-cycle restart on new enable or live select change
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      line_chk_q_r   <= 1'b0;
      lane_chk_q_r   <= 1'b0;
      line_sel_q_r   <= TPL_PAT_PRBS7;
      lane_sel_q_r   <= TPL_PAT_PRBS7;
      line_restart_r <= 1'b0;
      lane_restart_r <= 1'b0;
    end
    else
    begin
      line_chk_q_r   <= line_side_check_enable;
      lane_chk_q_r   <= lane_side_check_enable;
      line_sel_q_r   <= line_side_pattern_select;
      lane_sel_q_r   <= lane_side_pattern_select;
      line_restart_r <= line_side_check_enable
                     && (!line_chk_q_r || (line_sel_q_r != line_side_pattern_select));
      lane_restart_r <= lane_side_check_enable
                     && (!lane_chk_q_r || (lane_sel_q_r != lane_side_pattern_select));
    end
  end

  // ---------------------------------------------------------------
  // datapath controls
  // ---------------------------------------------------------------
  // unsupported patterns are held off rather than sent garbled
  assign LINE_CTRL.gen_active          = line_side_gen_enable && line_ok;
  assign LINE_CTRL.check_active        = line_side_check_enable && line_ok;
  assign LINE_CTRL.pattern             = line_side_pattern_select;
  assign LINE_CTRL.check_restart       = line_restart_r;
  assign LINE_CTRL.pattern_unsupported = !line_ok;
  assign LANE_CTRL.gen_active          = lane_side_gen_enable && lane_ok;
  assign LANE_CTRL.check_active        = lane_side_check_enable && lane_ok;
  assign LANE_CTRL.pattern             = lane_side_pattern_select;
  assign LANE_CTRL.check_restart       = lane_restart_r;
  assign LANE_CTRL.pattern_unsupported = !lane_ok;
  assign FAR_DEEP_LOOPBACK     = ctrl_r[`TPL_DEEP_LPBK_BIT];
  assign NEAR_SHALLOW_LOOPBACK = ctrl_r[`TPL_SHAL_LPBK_BIT];

  // ---------------------------------------------------------------
  // mismatch counter and readback
  // ---------------------------------------------------------------
  // saturating count, zeroed on each line checker restart so a run starts clean
  always_ff @(posedge CLK_SYS)
  begin
    if (RST || line_restart_r)
      errcnt_r <= `TPL_ERRCNT_ZERO;
    else if (LINE_CTRL.check_active && LINE_MISMATCH && (errcnt_r != `TPL_ERRCNT_MAX))
      errcnt_r <= errcnt_r + `TPL_ERRCNT_ONE;
  end

  // registered read data, unmapped addresses read zero
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      rdata_r <= `TPL_ERRCNT_ZERO;
    else if (MGMT_RD)
      rdata_r <= (MGMT_ADDR == `TPL_CTRL_ADDR)   ? ctrl_r :
                 (MGMT_ADDR == `TPL_ERRCNT_ADDR) ? errcnt_r : `TPL_ERRCNT_ZERO;
  end
  assign MGMT_RDATA = rdata_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_reset_default_value: assert property ($fell(RST) |-> ctrl_r == `TPL_CTRL_RESET)
    else $error("control register not at default after reset");
  // prbs is sendable in every mode but the unsupported one, where it must stay off
  a_line_gen_follow: assert property (
    (MGMT_WR && MGMT_ADDR == `TPL_CTRL_ADDR && MGMT_WDATA[`TPL_LINE_GEN_BIT]
     && MGMT_WDATA[`TPL_LINE_SEL_MSB:`TPL_LINE_SEL_LSB] == TPL_PAT_PRBS7)
    |=> (LINE_CTRL.gen_active == (DEV_MODE != TPL_MODE_OTHER))
        && LINE_CTRL.pattern == TPL_PAT_PRBS7)
    else $error("line generator not started by write");
  a_line_chk_off: assert property (
    (MGMT_WR && MGMT_ADDR == `TPL_CTRL_ADDR && !MGMT_WDATA[`TPL_LINE_CHK_BIT])
    |=> !LINE_CTRL.check_active)
    else $error("line checker active after clear");
  a_line_kr_crpat: assert property (
    (DEV_MODE == TPL_MODE_10G_KR && LINE_CTRL.pattern == TPL_PAT_CRPAT_LONG)
    |-> !LINE_CTRL.gen_active && LINE_CTRL.pattern_unsupported)
    else $error("line crpat allowed in kr mode");
  a_lane_sel_split: assert property (
    (MGMT_WR && MGMT_ADDR == `TPL_CTRL_ADDR)
    |=> LANE_CTRL.pattern == {$past(MGMT_WDATA[`TPL_LANE_SEL_HI_BIT]),
                              $past(MGMT_WDATA[`TPL_LANE_SEL_MSB:`TPL_LANE_SEL_LSB])})
    else $error("lane select assembled wrongly");
  // pattern judged from the decoded LANE_CTRL.pattern, not from the written word's select bits
  a_lane_chk_follow: assert property (
    (MGMT_WR && MGMT_ADDR == `TPL_CTRL_ADDR && MGMT_WDATA[`TPL_LANE_CHK_BIT])
    |=> LANE_CTRL.check_active == ((LANE_CTRL.pattern != TPL_PAT_CRPAT_LONG
                                    && LANE_CTRL.pattern != TPL_PAT_CRPAT_SHRT)
                                   || DEV_MODE == TPL_MODE_1G_KX))
    else $error("lane checker not active");
  a_lane_crpat_mode: assert property (
    (LANE_CTRL.gen_active && LANE_CTRL.pattern == TPL_PAT_CRPAT_SHRT)
    |-> DEV_MODE == TPL_MODE_1G_KX)
    else $error("lane crpat outside 1g-kx");
  a_deep_loop_bit: assert property (
    (MGMT_WR && MGMT_ADDR == `TPL_CTRL_ADDR)
    |=> FAR_DEEP_LOOPBACK == $past(MGMT_WDATA[`TPL_DEEP_LPBK_BIT]))
    else $error("deep loopback not following write");
  a_restart_on_enable: assert property (
    $rose(lane_side_check_enable) |=> LANE_CTRL.check_restart ##1 !LANE_CTRL.check_restart)
    else $error("lane checker not realigned once");
  a_errcnt_step: assert property (
    (LINE_CTRL.check_active && LINE_MISMATCH && !line_restart_r
     && errcnt_r != `TPL_ERRCNT_MAX)
    |=> errcnt_r == $past(errcnt_r) + `TPL_ERRCNT_ONE)
    else $error("mismatch not counted");

  c_line_prbs31: cover property (LINE_CTRL.gen_active && LINE_CTRL.pattern == TPL_PAT_PRBS31);
  c_lane_crpat: cover property (LANE_CTRL.check_active && LANE_CTRL.pattern == TPL_PAT_CRPAT_LONG);
  c_errs_counted: cover property (LINE_CTRL.check_active && errcnt_r == 16'h0003);
  c_both_loops: cover property (FAR_DEEP_LOOPBACK && NEAR_SHALLOW_LOOPBACK);

endmodule

/* File: inc/tpl_regs.svh */
`ifndef TPL_REGS_SVH
`define TPL_REGS_SVH

// ---------------------------------------------------------------
// management address map
// ---------------------------------------------------------------
`define TPL_ADDR_W          5
`define TPL_CTRL_ADDR       5'h0b
`define TPL_ERRCNT_ADDR     5'h0d
`define TPL_CTRL_RESET      16'h0d10

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define TPL_RSVD_HI_MSB     15
`define TPL_RSVD_HI_LSB     14
`define TPL_LINE_GEN_BIT    13
`define TPL_LINE_CHK_BIT    12
`define TPL_LANE_SEL_HI_BIT 11
`define TPL_LINE_SEL_MSB    10
`define TPL_LINE_SEL_LSB    8
`define TPL_LANE_GEN_BIT    7
`define TPL_LANE_CHK_BIT    6
`define TPL_LANE_SEL_MSB    5
`define TPL_LANE_SEL_LSB    4
`define TPL_DEEP_LPBK_BIT   3
`define TPL_RSVD_LO_MSB     2
`define TPL_RSVD_LO_LSB     1
`define TPL_SHAL_LPBK_BIT   0

// ---------------------------------------------------------------
// mismatch counter
// ---------------------------------------------------------------
`define TPL_ERRCNT_MAX      16'hffff
`define TPL_ERRCNT_ZERO     16'h0000
`define TPL_ERRCNT_ONE      16'h0001

`endif

/* File: inc/tpl_pkg.sv */
package tpl_pkg;

  // pattern select codes, shared by both sides
  typedef enum logic [2:0] {
    TPL_PAT_HIGH_FREQ  = 3'h0,
    TPL_PAT_LOW_FREQ   = 3'h1,
    TPL_PAT_MIXED_FREQ = 3'h2,
    TPL_PAT_CRPAT_LONG = 3'h3,
    TPL_PAT_CRPAT_SHRT = 3'h4,
    TPL_PAT_PRBS7      = 3'h5,
    TPL_PAT_PRBS23     = 3'h6,
    TPL_PAT_PRBS31     = 3'h7
  } tpl_pat_e;

  // operating mode of the transceiver core
  typedef enum logic [1:0] {
    TPL_MODE_1G_KX  = 2'h0,
    TPL_MODE_10G    = 2'h1,
    TPL_MODE_10G_KR = 2'h2,
    TPL_MODE_OTHER  = 2'h3
  } tpl_mode_e;

  // per-side control to the generator and checker
  typedef struct packed {
    logic     gen_active;
    logic     check_active;
    tpl_pat_e pattern;
    logic     check_restart;
    logic     pattern_unsupported;
  } tpl_side_s;

endpackage

/* File: test/tpl_far_end.sv */
`timescale 1ns/100ps
module tpl_far_end
  import tpl_pkg::*;
(
  // clock
  input  wire logic               clk_sys,
  // line side controls and corruption request
  input  wire tpl_pkg::tpl_side_s line_ctrl,
  input  wire logic               inject,
  // checker result
  output logic                    mismatch
);
  // ---------------------------------------------------------------
  // far end traffic checker
  // ---------------------------------------------------------------
  // mismatch only while comparing
  // a real checker is silent unless comparing, so corruption alone never counts
  always_ff @(posedge clk_sys)
  begin
    mismatch <= inject & line_ctrl.check_active;
  end
endmodule

/* File: test/tpl_control_test.sv */
`timescale 1ns/100ps
`include "tpl_regs.svh"
module tpl_control_test;
  import tpl_pkg::*;
  logic [`TPL_ADDR_W-1:0] mgmt_addr;
  logic                   clk_sys;
  logic                   rst;
  logic                   mgmt_wr;
  logic                   mgmt_rd;
  logic                   inject;
  logic                   mism;
  logic                   far_deep;
  logic                   near_shal;
  logic [15:0]            mgmt_wdata;
  logic [15:0]            mgmt_rdata;
  logic [15:0]            rd_val;
  logic [15:0]            val;
  tpl_mode_e              dev_mode;
  tpl_side_s              line_ctrl;
  tpl_side_s              lane_ctrl;
  int                     num_errors;
  int                     checks_done;
  int                     k;

  tpl_control dut (.CLK_SYS(clk_sys), .RST(rst), .MGMT_ADDR(mgmt_addr), .MGMT_WR(mgmt_wr),
    .MGMT_RD(mgmt_rd), .MGMT_WDATA(mgmt_wdata), .MGMT_RDATA(mgmt_rdata), .DEV_MODE(dev_mode),
    .LINE_MISMATCH(mism), .LINE_CTRL(line_ctrl), .LANE_CTRL(lane_ctrl),
    .FAR_DEEP_LOOPBACK(far_deep), .NEAR_SHALLOW_LOOPBACK(near_shal));
  tpl_far_end far (.clk_sys(clk_sys), .line_ctrl(line_ctrl), .inject(inject), .mismatch(mism));

  // ---------------------------------------------------------------
  // bus tasks, compares and expectations
  // ---------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge clk_sys);
    mgmt_wr = 1'b0;
    // idle cycle so a following call never re-raises the strobe in the same step
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [4:0] a);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge clk_sys);
    rd_val = mgmt_rdata;
    mgmt_rd = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chks(input tpl_side_s got, input tpl_side_s exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask
  function automatic tpl_side_s exps(logic g, logic c, logic [2:0] p, logic ok);
    tpl_side_s s;
    s = {g & ok, c & ok, p, 1'b0, ~ok};
    return s;
  endfunction
  function automatic logic line_ok(logic [2:0] p, logic [1:0] m);
    return (m != 2'h3) && (p >= 3'h5 || m <= 2'h1);
  endfunction
  function automatic logic lane_ok(logic [2:0] p, logic [1:0] m);
    return (p != 3'h3 && p != 3'h4) || m == 2'h0;
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {rst, mgmt_addr, mgmt_wr, mgmt_rd, mgmt_wdata, inject} = {1'b1, 24'h0};
    dev_mode = TPL_MODE_1G_KX;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(82051));
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    rd(`TPL_CTRL_ADDR);
    chk16(rd_val, `TPL_CTRL_RESET, "ctrl reset");
    chks(line_ctrl, exps(1'b0, 1'b0, 3'h5, 1'b1), "line reset");
    chks(lane_ctrl, exps(1'b0, 1'b0, 3'h5, 1'b1), "lane reset");
    $display("test reset done");
    // every code on both sides, random enables and modes
    for (int i = 0; i < 64; i++)
    begin
      val = 16'($urandom);
      val[10:8] = 3'(i);
      {val[11], val[5:4]} = 3'(i >> 3);
      dev_mode = tpl_mode_e'($urandom_range(3));
      wr(`TPL_CTRL_ADDR, val);
      repeat (2) @(negedge clk_sys);
      rd(`TPL_CTRL_ADDR);
      chk16(rd_val, val, "ctrl readback");
      chks(line_ctrl, exps(val[13], val[12], val[10:8], line_ok(val[10:8], dev_mode)),
        "line ctrl");
      chks(lane_ctrl, exps(val[7], val[6], {val[11], val[5:4]},
        lane_ok({val[11], val[5:4]}, dev_mode)), "lane ctrl");
      chk16({14'h0, far_deep, near_shal}, {14'h0, val[3], val[0]}, "loopback");
    end
    $display("test decode done");
    wr(5'h1f, 16'hffff);
    rd(`TPL_CTRL_ADDR);
    chk16(rd_val, val, "unmapped write");
    rd(5'h1f);
    chk16(rd_val, 16'h0, "unmapped read");
    $display("test unmapped done");
    // counted mismatches, then cleared by a live select change
    dev_mode = TPL_MODE_1G_KX;
    wr(`TPL_CTRL_ADDR, 16'h0d10);
    wr(`TPL_CTRL_ADDR, 16'h1d10);
    repeat (4) @(negedge clk_sys);
    k = $urandom_range(9, 2);
    inject = 1'b1;
    repeat (k) @(negedge clk_sys);
    inject = 1'b0;
    repeat (3) @(negedge clk_sys);
    rd(`TPL_ERRCNT_ADDR);
    chk16(rd_val, 16'(k), "mismatch count");
    wr(`TPL_CTRL_ADDR, 16'h1e10);
    chk16({15'h0, line_ctrl.check_restart}, 16'h1, "restart pulse");
    repeat (2) @(negedge clk_sys);
    rd(`TPL_ERRCNT_ADDR);
    chk16(rd_val, 16'h0, "count cleared");
    chks(line_ctrl, exps(1'b0, 1'b1, 3'h6, 1'b1), "live select");
    $display("test counter done");
    results();
  end
endmodule
